// File: menu_pkg.sv
package menu_pkg;
  // Clock and time base
  localparam int CLK_HZ = 20_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_DIV = CLK_HZ / MS_PER_S;
  localparam int TIMEOUT_S = 3;
  localparam int TIMEOUT_MS = TIMEOUT_S * MS_PER_S;
  localparam int HOLD_S = 3;
  localparam int HOLD_MS = HOLD_S * MS_PER_S;
  localparam int DEBOUNCE_MS = 20;
  localparam int MS_CNT_W = 13;

  // Settings table: index, code, default value (BCD), number of choices (0 = numeric)
  localparam int NSET = 9;
  localparam int SET_PRESS_UNIT = 0;
  localparam int SET_TEMP_UNIT = 1;
  localparam int SET_PUMP_RATIO = 2;
  localparam int SET_IDLE_RPM = 3;
  localparam int SET_WARN_PUMP = 4;
  localparam int SET_CUT_PUMP = 5;
  localparam int SET_OIL_WARN = 6;
  localparam int SET_OIL_CUT = 7;
  localparam int SET_AUTO_ON = 8;
  localparam logic [11:0] SET_CODE [NSET] = '{12'h310, 12'h311, 12'h312, 12'h313, 12'h314,
                                              12'h315, 12'h316, 12'h317, 12'h321};
  localparam logic [15:0] SET_DEFAULT [NSET] = '{16'h0000, 16'h0000, 16'h0244, 16'h0900, 16'h3650,
                                                 16'h4500, 16'h0212, 16'h0240, 16'h0000};
  localparam logic [3:0] SET_CHOICES [NSET] = '{4'h3, 4'h2, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h2};
  localparam logic [11:0] CODE_FIRST = 12'h100;
  localparam logic [15:0] PCT_SCALE = 16'h0064;

  // Display digit codes beyond 0-9, and the highest decimal digit
  localparam logic [3:0] DIG_BLANK = 4'hA;
  localparam logic [3:0] DIG_ERR = 4'hE;
  localparam logic [3:0] DIG_DASH = 4'hF;
  localparam logic [3:0] DIG_MAX = 4'h9;

  // AXI4-Lite register map (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_DISPLAY = 8'h08;
  localparam logic [ADDR_W-1:0] REG_SET_BASE = 8'h20;
  localparam int CTRL_LOCK_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {ST_NORMAL, ST_DASHES, ST_CODE, ST_EDIT, ST_ERROR} menu_state_t;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;

  typedef struct packed {
    logic valid;
    logic [3:0] index;
    logic [15:0] data;
  } nv_word_t;

  typedef struct packed {
    logic rpm_ok;
    logic overspeed;
    logic disengage;
    logic oil_warn;
    logic oil_cut;
  } limits_t;

  typedef struct packed {
    logic temp_c;
    logic [1:0] press_unit;
    logic auto_on;
  } options_t;
endpackage

// File: btn_conditioner.sv
`timescale 1ns/1ps
module btn_conditioner
  import menu_pkg::*;
#(
  parameter int N = 2,
  parameter int DEB_MS = DEBOUNCE_MS
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ms_tick_in,
  input wire logic [N-1:0] raw_in,
  output logic [N-1:0] level_out
);
  localparam logic [7:0] DEB_LAST = 8'(DEB_MS);

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_btn
      logic meta_q;
      logic sync_q;
      logic [7:0] stable_q;
      logic level_q;

      // Two-stage synchroniser; only sync_q is looked at
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= raw_in[i];
          sync_q <= meta_q;
        end
      end

      // Level accepted only after staying put for the whole debounce window
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          stable_q <= 8'h00;
          level_q <= 1'b0;
        end else if (sync_q == level_q) begin
          stable_q <= 8'h00;
        end else if (ms_tick_in) begin
          if (stable_q >= DEB_LAST - 8'h01) begin
            level_q <= sync_q;
            stable_q <= 8'h00;
          end else begin
            stable_q <= stable_q + 8'h01;
          end
        end
      end
      // Each bit keeps its own flop, so the vector has one driver per bit
      assign level_out[i] = level_q;
    end
  endgenerate
endmodule

// File: button_settings_menu.sv
`timescale 1ns/1ps
// Functional notes
// - In the settings state, three seconds without button input returns to normal.
// - Holding MODE enters settings; four dashes show, ready for a code.
// - Every setting is reached only through a three-digit decimal code.
// - First ON/OFF after dashes shows 100, leading digit flashing; ON/OFF raises it.
// - MODE moves the cursor to the middle digit; further MODE raises it.
// - Next ON/OFF moves to the last digit; further ON/OFF raises it.
// - Known code shows its stored value or option; unknown code shows an error.
// - While a known code's value is shown, the inactivity timeout is suspended.
// - While editing, MODE picks the flashing digit; ON/OFF changes it or the option.
// - MODE then ON/OFF held together leaves editing; four dashes then show.
// - After that exit a new code is accepted, or three idle seconds end the menu.
// - 311 picks Fahrenheit or Celsius, default F; 310 picks psi, kPa or bar.
// - 313 holds the highest engine speed allowing engagement, default 900.
// - 314 holds the pump speed for overspeed warning, default 3650.
// - 315 holds the pump speed for automatic disengagement, default 4500.
// - 316 holds the oil overheat warning temperature, default 212 F.
// - 317 holds the oil temperature for disengagement, default 240 F.
// - 321 holds the auto-on with interlock option, default off.
// - A separate setting holds the pump ratio, default 2.44.
// - Pump-speed limits are divided by the pump ratio before comparing engine speed.
module button_settings_menu
  import menu_pkg::*;
#(
  parameter int MS_CYCLES = MS_DIV,
  parameter int TIMEOUT_TICKS = TIMEOUT_MS,
  parameter int HOLD_TICKS = HOLD_MS
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic MODE_BTN_IN,
  input wire logic ONOFF_BTN_IN,
  input wire logic [13:0] ENGINE_RPM_IN,
  input wire logic [9:0] OIL_TEMP_F_IN,
  input wire nv_word_t NV_LOAD_IN,
  input wire axi_req_t S_AXI_REQ_IN,
  output axi_rsp_t S_AXI_RSP_OUT,
  output nv_word_t NV_SAVE_OUT,
  output logic [15:0] DISP_DIGITS_OUT,
  output logic [3:0] DISP_FLASH_OUT,
  output logic MENU_ACTIVE_OUT,
  output limits_t LIMITS_OUT,
  output options_t OPTIONS_OUT
);
  localparam logic [MS_CNT_W-1:0] TIMEOUT_LAST = MS_CNT_W'(TIMEOUT_TICKS);
  localparam logic [MS_CNT_W-1:0] HOLD_LAST = MS_CNT_W'(HOLD_TICKS);
  localparam logic [14:0] DIV_LAST = 15'(MS_CYCLES - 1);

  // Packed BCD to binary, four digits
  function automatic logic [13:0] bcd2bin(input logic [15:0] b);
    bcd2bin = 14'((((b[15:12] * 4'd10) + 14'(b[11:8])) * 14'd10 + 14'(b[7:4])) * 14'd10 + 14'(b[3:0]));
  endfunction

  // Decimal digit increment with wrap
  function automatic logic [3:0] dig_inc(input logic [3:0] d);
    dig_inc = (d >= DIG_MAX) ? 4'h0 : d + 4'h1;
  endfunction

  logic [14:0] div_q;
  logic ms_tick_q;
  logic [1:0] level;
  logic [1:0] level_q;
  logic [1:0] released;
  logic spoiled_q;
  logic [MS_CNT_W-1:0] mode_hold_q;
  logic [MS_CNT_W-1:0] both_hold_q;
  logic mode_hold_fire;
  logic both_hold_fire;
  logic [MS_CNT_W-1:0] idle_q;
  logic timeout_hit;
  logic mode_rel;
  logic on_rel;
  menu_state_t state_q;
  logic [1:0] cursor_q;
  logic [11:0] code_q;
  logic [3:0] sel_q;
  logic code_hit;
  logic [3:0] code_idx;
  logic [15:0] set_q [NSET];
  logic lock_q;
  logic edit_wr;
  logic [15:0] edit_val;
  logic leave_edit;
  logic aw_wait_q;
  logic w_wait_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bus_wr;
  logic [31:0] rd_val;
  logic rd_ok;
  logic [3:0] wr_idx;
  logic wr_is_set;
  logic [ADDR_W-1:0] wr_off, rd_off;
  logic [27:0] rpm_scaled;

  // Millisecond enable; the only slower rate in the block
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      div_q <= 15'h0000;
      ms_tick_q <= 1'b0;
    end else begin
      ms_tick_q <= (div_q == DIV_LAST);
      div_q <= (div_q == DIV_LAST) ? 15'h0000 : div_q + 15'h0001;
    end
  end

  btn_conditioner #(.N(2), .DEB_MS(DEBOUNCE_MS)) u_btn (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .ms_tick_in(ms_tick_q),
    .raw_in({ONOFF_BTN_IN, MODE_BTN_IN}),
    .level_out(level)
  );

  // Short presses act on release, so a chord or a long MODE hold never nudges a digit
  assign released = level_q & ~level;
  assign mode_rel = released[0] & ~level[1] & ~spoiled_q;
  assign on_rel = released[1] & ~level[0] & ~spoiled_q;
  assign mode_hold_fire = ms_tick_q && level == 2'b01 && mode_hold_q == HOLD_LAST - 1'b1;
  assign both_hold_fire = ms_tick_q && level == 2'b11 && both_hold_q == HOLD_LAST - 1'b1;

  // Press history: previous level and the spoil flag for chords and holds
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      level_q <= 2'b00;
      spoiled_q <= 1'b0;
    end else begin
      level_q <= level;
      if (level == 2'b00) begin
        spoiled_q <= 1'b0;
      end else if (level == 2'b11 || mode_hold_fire || both_hold_fire) begin
        spoiled_q <= 1'b1;
      end
    end
  end

  // Hold timers in milliseconds
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      mode_hold_q <= '0;
      both_hold_q <= '0;
    end else begin
      if (level != 2'b01) begin
        mode_hold_q <= '0;
      end else if (ms_tick_q && mode_hold_q != HOLD_LAST) begin
        mode_hold_q <= mode_hold_q + 1'b1;
      end
      if (level != 2'b11) begin
        both_hold_q <= '0;
      end else if (ms_tick_q && both_hold_q != HOLD_LAST) begin
        both_hold_q <= both_hold_q + 1'b1;
      end
    end
  end

  // Inactivity timer; held at zero in normal state, while editing, or while any button is down
  assign timeout_hit = ms_tick_q && idle_q == TIMEOUT_LAST - 1'b1;
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      idle_q <= '0;
    end else if (level != 2'b00 || level_q != 2'b00 || state_q == ST_EDIT || state_q == ST_NORMAL) begin
      idle_q <= '0;
    end else if (ms_tick_q) begin
      idle_q <= idle_q + 1'b1;
    end
  end

  // Code lookup
  always_comb begin
    code_hit = 1'b0;
    code_idx = 4'h0;
    for (int i = 0; i < NSET; i++) begin
      if (code_q == SET_CODE[i]) begin
        code_hit = 1'b1;
        code_idx = 4'(i);
      end
    end
  end

  assign leave_edit = state_q == ST_EDIT && both_hold_fire;

  // Menu sequencer
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_q <= ST_NORMAL;
      cursor_q <= 2'h0;
      code_q <= 12'h000;
      sel_q <= 4'h0;
    end else begin
      unique case (state_q)
        ST_NORMAL: begin
          if (mode_hold_fire && !lock_q) begin
            state_q <= ST_DASHES;
          end
        end
        ST_DASHES: begin
          if (timeout_hit) begin
            state_q <= ST_NORMAL;
          end else if (on_rel) begin
            code_q <= CODE_FIRST;
            cursor_q <= 2'h0;
            state_q <= ST_CODE;
          end
        end
        ST_CODE: begin
          if (timeout_hit) begin
            state_q <= ST_NORMAL;
          end else begin
            unique case (cursor_q)
              2'h0: begin
                if (on_rel) begin
                  code_q[11:8] <= dig_inc(code_q[11:8]);
                end else if (mode_rel) begin
                  cursor_q <= 2'h1;
                end
              end
              2'h1: begin
                if (mode_rel) begin
                  code_q[7:4] <= dig_inc(code_q[7:4]);
                end else if (on_rel) begin
                  cursor_q <= 2'h2;
                end
              end
              default: begin
                if (on_rel) begin
                  code_q[3:0] <= dig_inc(code_q[3:0]);
                end else if (mode_rel) begin
                  cursor_q <= 2'h0;
                  sel_q <= code_idx;
                  state_q <= code_hit ? ST_EDIT : ST_ERROR;
                end
              end
            endcase
          end
        end
        ST_EDIT: begin
          if (both_hold_fire) begin
            state_q <= ST_DASHES;
          end else if (mode_rel) begin
            cursor_q <= cursor_q + 2'h1;
          end
        end
        ST_ERROR: begin
          if (timeout_hit) begin
            state_q <= ST_NORMAL;
          end else if (on_rel || mode_rel) begin
            state_q <= ST_DASHES;
          end
        end
        default: state_q <= ST_NORMAL;
      endcase
    end
  end

  // New value for the setting under edit
  always_comb begin
    edit_val = set_q[sel_q];
    edit_wr = state_q == ST_EDIT && on_rel;
    if (SET_CHOICES[sel_q] != 4'h0) begin
      edit_val[3:0] = (set_q[sel_q][3:0] + 4'h1 >= SET_CHOICES[sel_q]) ? 4'h0 : set_q[sel_q][3:0] + 4'h1;
    end else begin
      unique case (cursor_q)
        2'h0: edit_val[15:12] = dig_inc(set_q[sel_q][15:12]);
        2'h1: edit_val[11:8] = dig_inc(set_q[sel_q][11:8]);
        2'h2: edit_val[7:4] = dig_inc(set_q[sel_q][7:4]);
        default: edit_val[3:0] = dig_inc(set_q[sel_q][3:0]);
      endcase
    end
  end

  // Settings store; menu edit beats a restore, which beats a bus write
  assign wr_off = (awaddr_q - REG_SET_BASE) >> 2; // Range test on the full offset, so no far address aliases
  assign wr_idx = wr_off[3:0];
  assign wr_is_set = awaddr_q >= REG_SET_BASE && wr_off < ADDR_W'(NSET) && awaddr_q[1:0] == 2'b00;
  genvar g;
  generate
    for (g = 0; g < NSET; g++) begin : g_set
      always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
          set_q[g] <= SET_DEFAULT[g];
        end else if (edit_wr && sel_q == 4'(g)) begin
          set_q[g] <= edit_val;
        end else if (NV_LOAD_IN.valid && NV_LOAD_IN.index == 4'(g)) begin
          set_q[g] <= NV_LOAD_IN.data;
        end else if (bus_wr && wr_is_set && wr_idx == 4'(g)) begin
          if (wstrb_q[0]) begin
            set_q[g][7:0] <= wdata_q[7:0];
          end
          if (wstrb_q[1]) begin
            set_q[g][15:8] <= wdata_q[15:8];
          end
        end
      end
    end
  endgenerate

  // Save the edited word to nonvolatile storage when editing is left
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      NV_SAVE_OUT <= '0;
    end else begin
      NV_SAVE_OUT.valid <= leave_edit;
      NV_SAVE_OUT.index <= sel_q;
      NV_SAVE_OUT.data <= set_q[sel_q];
    end
  end

  // Display drive
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      DISP_DIGITS_OUT <= {4{DIG_BLANK}};
      DISP_FLASH_OUT <= 4'h0;
      MENU_ACTIVE_OUT <= 1'b0;
    end else begin
      MENU_ACTIVE_OUT <= state_q != ST_NORMAL;
      unique case (state_q)
        ST_NORMAL: begin
          DISP_DIGITS_OUT <= {4{DIG_BLANK}};
          DISP_FLASH_OUT <= 4'h0;
        end
        ST_DASHES: begin
          DISP_DIGITS_OUT <= {4{DIG_DASH}};
          DISP_FLASH_OUT <= 4'h0;
        end
        ST_CODE: begin
          DISP_DIGITS_OUT <= {DIG_BLANK, code_q};
          DISP_FLASH_OUT <= 4'h4 >> cursor_q;
        end
        ST_EDIT: begin
          DISP_DIGITS_OUT <= set_q[sel_q];
          DISP_FLASH_OUT <= (SET_CHOICES[sel_q] != 4'h0) ? 4'h1 : 4'h8 >> cursor_q;
        end
        ST_ERROR: begin
          DISP_DIGITS_OUT <= {DIG_ERR, code_q};
          DISP_FLASH_OUT <= 4'hF;
        end
        default: begin
          DISP_DIGITS_OUT <= {4{DIG_BLANK}};
          DISP_FLASH_OUT <= 4'h0;
        end
      endcase
    end
  end

  // Pump-speed limits: engine rpm times ratio (hundredths) against pump rpm times 100
  assign rpm_scaled = 28'(ENGINE_RPM_IN) * 28'(bcd2bin(set_q[SET_PUMP_RATIO]));
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      LIMITS_OUT <= '0;
      OPTIONS_OUT <= '0;
    end else begin
      LIMITS_OUT.rpm_ok <= ENGINE_RPM_IN <= bcd2bin(set_q[SET_IDLE_RPM]);
      LIMITS_OUT.overspeed <= rpm_scaled >= 28'(bcd2bin(set_q[SET_WARN_PUMP])) * 28'(PCT_SCALE);
      LIMITS_OUT.disengage <= rpm_scaled >= 28'(bcd2bin(set_q[SET_CUT_PUMP])) * 28'(PCT_SCALE);
      LIMITS_OUT.oil_warn <= 14'(OIL_TEMP_F_IN) >= bcd2bin(set_q[SET_OIL_WARN]);
      LIMITS_OUT.oil_cut <= 14'(OIL_TEMP_F_IN) >= bcd2bin(set_q[SET_OIL_CUT]);
      OPTIONS_OUT.temp_c <= set_q[SET_TEMP_UNIT][0];
      OPTIONS_OUT.press_unit <= set_q[SET_PRESS_UNIT][1:0];
      OPTIONS_OUT.auto_on <= set_q[SET_AUTO_ON][0];
    end
  end

  // AXI4-Lite write: address and data held until both present, then one answer
  assign bus_wr = aw_wait_q && w_wait_q && !S_AXI_RSP_OUT.bvalid;
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      aw_wait_q <= 1'b0;
      w_wait_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      S_AXI_RSP_OUT.awready <= 1'b1;
      S_AXI_RSP_OUT.wready <= 1'b1;
      S_AXI_RSP_OUT.bvalid <= 1'b0;
      S_AXI_RSP_OUT.bresp <= RESP_OKAY;
      lock_q <= 1'b0;
    end else begin
      if (S_AXI_REQ_IN.awvalid && S_AXI_RSP_OUT.awready) begin
        aw_wait_q <= 1'b1;
        awaddr_q <= S_AXI_REQ_IN.awaddr;
        S_AXI_RSP_OUT.awready <= 1'b0;
      end
      if (S_AXI_REQ_IN.wvalid && S_AXI_RSP_OUT.wready) begin
        w_wait_q <= 1'b1;
        wdata_q <= S_AXI_REQ_IN.wdata;
        wstrb_q <= S_AXI_REQ_IN.wstrb;
        S_AXI_RSP_OUT.wready <= 1'b0;
      end
      if (bus_wr) begin
        S_AXI_RSP_OUT.bvalid <= 1'b1;
        S_AXI_RSP_OUT.bresp <= (wr_is_set || awaddr_q == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
        if (awaddr_q == REG_CTRL && wstrb_q[0]) begin
          lock_q <= wdata_q[CTRL_LOCK_BIT]; // Lock blocks menu entry, e.g. while pumping
        end
      end
      if (S_AXI_RSP_OUT.bvalid && S_AXI_REQ_IN.bready) begin
        S_AXI_RSP_OUT.bvalid <= 1'b0;
        aw_wait_q <= 1'b0;
        w_wait_q <= 1'b0;
        S_AXI_RSP_OUT.awready <= 1'b1;
        S_AXI_RSP_OUT.wready <= 1'b1;
      end
    end
  end

  // Read decode
  assign rd_off = (S_AXI_REQ_IN.araddr - REG_SET_BASE) >> 2;
  always_comb begin
    rd_val = 32'h00000000;
    rd_ok = 1'b1;
    if (S_AXI_REQ_IN.araddr == REG_CTRL) begin
      rd_val[CTRL_LOCK_BIT] = lock_q;
    end else if (S_AXI_REQ_IN.araddr == REG_STATUS) begin
      rd_val = {4'h0, code_q, 4'h0, sel_q, 2'h0, cursor_q, 1'b0, state_q};
    end else if (S_AXI_REQ_IN.araddr == REG_DISPLAY) begin
      rd_val = {12'h000, DISP_FLASH_OUT, DISP_DIGITS_OUT};
    end else if (S_AXI_REQ_IN.araddr >= REG_SET_BASE && S_AXI_REQ_IN.araddr[1:0] == 2'b00 &&
                 rd_off < ADDR_W'(NSET)) begin
      rd_val = {16'h0000, set_q[rd_off[3:0]]};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // AXI4-Lite read: answer one cycle after the address is taken
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      S_AXI_RSP_OUT.arready <= 1'b1;
      S_AXI_RSP_OUT.rvalid <= 1'b0;
      S_AXI_RSP_OUT.rdata <= 32'h00000000;
      S_AXI_RSP_OUT.rresp <= RESP_OKAY;
    end else if (S_AXI_REQ_IN.arvalid && S_AXI_RSP_OUT.arready) begin
      S_AXI_RSP_OUT.arready <= 1'b0;
      S_AXI_RSP_OUT.rvalid <= 1'b1;
      S_AXI_RSP_OUT.rdata <= rd_val;
      S_AXI_RSP_OUT.rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RSP_OUT.rvalid && S_AXI_REQ_IN.rready) begin
      S_AXI_RSP_OUT.rvalid <= 1'b0;
      S_AXI_RSP_OUT.arready <= 1'b1;
    end
  end
endmodule

// File: menu_chk.sv
`timescale 1ns/1ps
module menu_chk
  import menu_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic MODE_BTN_IN,
  input wire logic ONOFF_BTN_IN,
  input wire axi_req_t S_AXI_REQ_IN,
  input wire axi_rsp_t S_AXI_RSP_OUT,
  input wire nv_word_t NV_SAVE_OUT,
  input wire logic [15:0] DISP_DIGITS_OUT,
  input wire logic MENU_ACTIVE_OUT
);
  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // Both write halves taken at one edge
  sequence s_wr;
    S_AXI_REQ_IN.awvalid && S_AXI_RSP_OUT.awready && S_AXI_REQ_IN.wvalid && S_AXI_RSP_OUT.wready;
  endsequence
  sequence s_rd;
    S_AXI_REQ_IN.arvalid && S_AXI_RSP_OUT.arready;
  endsequence
  // Both halves are latched first and the answer is registered after, so it shows two edges on
  a_wr_answer: assert property (s_wr |=> ##1 S_AXI_RSP_OUT.bvalid) else $error("no write answer");
  a_wr_unmapped: assert property (s_wr ##0 S_AXI_REQ_IN.awaddr > 8'h40 |=> ##1 S_AXI_RSP_OUT.bresp == RESP_SLVERR)
    else $error("bad write accepted");
  a_rd_answer: assert property (s_rd |=> S_AXI_RSP_OUT.rvalid) else $error("no read answer");
  a_rd_block: assert property (S_AXI_RSP_OUT.rvalid |-> !S_AXI_RSP_OUT.arready) else $error("read overlap");
  a_menu_entry: assert property ($rose(MENU_ACTIVE_OUT) |-> MODE_BTN_IN ##[0:1] DISP_DIGITS_OUT == 16'hFFFF)
    else $error("bad menu entry");
  a_quiet_exit: assert property ($fell(MENU_ACTIVE_OUT) |-> !MODE_BTN_IN && !ONOFF_BTN_IN)
    else $error("menu left while pressed");
  a_save_pulse: assert property (NV_SAVE_OUT.valid |-> MENU_ACTIVE_OUT ##1 !NV_SAVE_OUT.valid)
    else $error("save pulse too long");
  a_save_dashes: assert property (NV_SAVE_OUT.valid |-> ##[0:1] DISP_DIGITS_OUT == 16'hFFFF)
    else $error("save without dashes");
endmodule
bind button_settings_menu menu_chk menu_chk_inst (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .MODE_BTN_IN(MODE_BTN_IN),
  .ONOFF_BTN_IN(ONOFF_BTN_IN), .S_AXI_REQ_IN(S_AXI_REQ_IN), .S_AXI_RSP_OUT(S_AXI_RSP_OUT),
  .NV_SAVE_OUT(NV_SAVE_OUT), .DISP_DIGITS_OUT(DISP_DIGITS_OUT), .MENU_ACTIVE_OUT(MENU_ACTIVE_OUT));

// File: button_operator.sv
`timescale 1ns/1ps
module button_operator #(
  parameter int MS = 4
) (
  input wire logic clk_in,
  output logic mode_out,
  output logic onoff_out
);
  // Both buttons start released
  initial begin
    mode_out = 1'b0;
    onoff_out = 1'b0;
  end
  // Ends on a rising edge so the caller may drive at once
  task automatic wait_ms(input int n);
    repeat (n * MS) @(posedge clk_in);
  endtask
  // Outlasts the 20 ms debounce but stays short of a hold
  task automatic tap(input logic on);
    if (on) onoff_out <= 1'b1;
    else mode_out <= 1'b1;
    wait_ms(24);
    {mode_out, onoff_out} <= 2'b00;
    wait_ms(24);
  endtask
  // MODE alone, or MODE then ON/OFF, held past the hold time
  task automatic hold(input logic both);
    mode_out <= 1'b1;
    wait_ms(2);
    onoff_out <= both;
    wait_ms(70);
    {mode_out, onoff_out} <= 2'b00;
    wait_ms(24);
  endtask
endmodule

// File: button_settings_menu_test.sv
`timescale 1ns/1ps
module button_settings_menu_test;
  import menu_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, mode, onoff, active;
  logic [13:0] rpm = '0;
  logic [9:0] oil = '0;
  logic [15:0] digits, idle;
  logic [3:0] flash;
  logic [1:0] r;
  axi_req_t req = '0;
  axi_rsp_t rsp;
  nv_word_t nv_save, nv_seen = '0;
  nv_word_t nv_load = '0;
  limits_t limits;
  options_t options;
  integer seed = 27568;
  int num_errors = 0, checks_done = 0, cyc = 0;
  logic [15:0] defs [9] = '{16'h0, 16'h0, 16'h244, 16'h900, 16'h3650, 16'h4500, 16'h212, 16'h240, 16'h0};
  always #25 clk = ~clk;
  // Short counts keep the run small: 4-cycle ms, 40 ms hold and timeout
  button_settings_menu #(.MS_CYCLES(4), .TIMEOUT_TICKS(40), .HOLD_TICKS(40)) button_settings_menu_inst (
    .CLK_IN(clk), .RST_N_IN(rst_n), .MODE_BTN_IN(mode), .ONOFF_BTN_IN(onoff), .ENGINE_RPM_IN(rpm),
    .OIL_TEMP_F_IN(oil), .NV_LOAD_IN(nv_load), .S_AXI_REQ_IN(req), .S_AXI_RSP_OUT(rsp), .NV_SAVE_OUT(nv_save),
    .DISP_DIGITS_OUT(digits), .DISP_FLASH_OUT(flash), .MENU_ACTIVE_OUT(active), .LIMITS_OUT(limits),
    .OPTIONS_OUT(options));
  button_operator opr (.clk_in(clk), .mode_out(mode), .onoff_out(onoff));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // The save pulse lasts one cycle, so keep the last word; also cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (nv_save.valid) nv_seen <= nv_save;
    if (cyc == 20000) begin
      num_errors++;
      conclude();
    end
  end
  // Extra edge at the end so a following call never re-drives in the same step
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= v;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    @(posedge clk);
    while (!rsp.bvalid) begin
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      @(posedge clk);
    end
    resp = rsp.bresp;
    req.bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    @(posedge clk);
    while (!rsp.rvalid) begin
      if (rsp.arready) req.arvalid <= 1'b0;
      @(posedge clk);
    end
    cmp(rsp.rdata, e);
    cmp(rsp.rresp, er);
    req.rready <= 1'b0;
    @(posedge clk);
  endtask
  // Expected limit flags with the default pump ratio of 2.44
  function automatic limits_t lim(input logic [13:0] e, input logic [9:0] t, input logic [15:0] i);
    int v;
    v = i[15:12] * 1000 + i[11:8] * 100 + i[7:4] * 10 + i[3:0];
    return '{e <= v, e * 244 >= 365000, e * 244 >= 450000, t >= 212, t >= 240};
  endfunction
  // Key in a three-digit code, watching the cursor move
  task automatic code(input int a, input int b, input int c);
    opr.tap(1'b1);
    cmp({flash, digits[11:0]}, {4'b0100, 12'h100});
    repeat (a - 1) opr.tap(1'b1);
    opr.tap(1'b0);
    repeat (b) opr.tap(1'b0);
    cmp(flash, 4'b0010);
    opr.tap(1'b1);
    repeat (c) opr.tap(1'b1);
    cmp({flash, digits[11:0]}, {4'b0001, 4'(a), 4'(b), 4'(c)});
    opr.tap(1'b0);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    cmp(options, '0);
    for (int i = 0; i < 9; i++) rdc(8'h20 + 8'(4 * i), {16'h0, defs[i]}, RESP_OKAY);
    rdc(8'h80, 32'h0, RESP_SLVERR);
    rdc(8'h08, 32'h0000AAAA, RESP_OKAY);
    wr(8'h80, 32'h1234, r);
    cmp(r, RESP_SLVERR);
    // Leading 9 so the edit below must wrap
    idle = 16'h9000;
    for (int k = 0; k < 3; k++) idle[k*4 +: 4] = 4'($unsigned($random(seed)) % 10);
    wr(8'h2C, {16'h0, idle}, r);
    rdc(8'h2C, {16'h0, idle}, RESP_OKAY);
    for (int k = 0; k < 12; k++) begin
      rpm <= (k < 2) ? 14'(k * 1500) : 14'($random(seed));
      oil <= 10'($unsigned($random(seed)) % 300);
      repeat (2) @(posedge clk);
      cmp(limits, lim(rpm, oil, idle));
    end
    // Restore pulse from storage sets the auto-on option
    nv_load <= '{1'b1, 4'h8, 16'h0001};
    @(posedge clk);
    nv_load.valid <= 1'b0;
    repeat (2) @(posedge clk);
    cmp(options, 4'h1);
    rdc(8'h40, 32'h1, RESP_OKAY);
    // Locked unit ignores the MODE hold
    wr(8'h00, 32'h1, r);
    cmp(r, RESP_OKAY);
    rdc(8'h00, 32'h1, RESP_OKAY);
    opr.hold(1'b0);
    cmp(active, 1'b0);
    wr(8'h00, 32'h0, r);
    opr.hold(1'b0);
    cmp({active, digits}, {1'b1, 16'hFFFF});
    code(3, 1, 3);
    cmp({flash, digits}, {4'b1000, idle});
    opr.wait_ms(60);
    cmp(active, 1'b1);
    opr.tap(1'b1);
    opr.tap(1'b0);
    cmp({flash, digits}, {4'b0100, 4'h0, idle[11:0]});
    opr.hold(1'b1);
    cmp(digits, 16'hFFFF);
    cmp(nv_seen, {1'b1, 4'h3, 4'h0, idle[11:0]});
    rdc(8'h2C, {20'h0, idle[11:0]}, RESP_OKAY);
    opr.wait_ms(60);
    cmp(active, 1'b0);
    opr.hold(1'b0);
    code(1, 0, 0);
    cmp({flash, digits}, {4'hF, 16'hE100});
    opr.wait_ms(60);
    cmp(active, 1'b0);
    conclude();
  end
endmodule
